/* File: msq_cfg.svh */
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH

// clock and timing, in ns
`define MSQ_CLK_PERIOD_NS 10
`define MSQ_TICK_NS       100000
`define MSQ_SHORT_NS      8000
`define MSQ_OPEN_NS       2000
`define MSQ_CHARGE_NS     1000
`define MSQ_PORT_IV0_NS   64000
`define MSQ_PORT_IV1_NS   128000
`define MSQ_PORT_IV2_NS   256000
`define MSQ_PORT_IV3_NS   512000

// register byte offsets
`define MSQ_A_CTRL    12'h000
`define MSQ_A_CMD     12'h004
`define MSQ_A_STAT    12'h008
`define MSQ_A_RES_REF 12'h00C
`define MSQ_A_RES_SEN 12'h010
`define MSQ_A_FLIGHT  12'h014
`define MSQ_A_TEMP    12'h018

// control fields
`define MSQ_F_DUMMY  2:0
`define MSQ_F_PORTIV 4:3
`define MSQ_F_CONT   5
`define MSQ_F_IRQPM  6
`define MSQ_F_FRATE  10:7
`define MSQ_F_FCNT   15:11
`define MSQ_F_TCNT   20:16
`define MSQ_F_CALB0  21
`define MSQ_F_CALB1  22
`define MSQ_F_INTEN  24
`define MSQ_F_TRATE  28:25
`define MSQ_F_RAND   29
`define MSQ_CTRL_RST  32'h0000_0000
`define MSQ_CTRL_MASK 32'h3FFF_FFFF

// command bits
`define MSQ_C_FLIGHT 0
`define MSQ_C_TEMP   1
`define MSQ_C_BOTH   2
`define MSQ_C_HALT   3
`define MSQ_C_SINGLE 4

// status bits
`define MSQ_S_TDONE 0
`define MSQ_S_TOPEN 1
`define MSQ_S_FSEQ  2
`define MSQ_S_TSEQ  3
`define MSQ_S_MEAS  4
`define MSQ_S_BUSY  5
`define MSQ_NFLAGS  5

`define MSQ_SHORT_VAL 16'h0000
`define MSQ_OPEN_VAL  16'hFFFF
`define MSQ_LFSR_SEED 9'h1A5

// rate tables in 100 us ticks, code 0 in the low slice
`define MSQ_NOM_TBL {15'd1250, 15'd1333, 15'd1429, 15'd1538, 15'd1667, 15'd1818, 15'd2000, 15'd2222, \
  15'd2500, 15'd2857, 15'd3333, 15'd4000, 15'd5000, 15'd6667, 15'd10000, 15'd20000}
`define MSQ_MIN_TBL {11'd1110, 11'd1090, 11'd1070, 11'd1050, 11'd1030, 11'd1010, 11'd1000, 11'd980, \
  11'd960, 11'd940, 11'd920, 11'd900, 11'd880, 11'd860, 11'd840, 11'd820}
`define MSQ_LSB_TBL {9'd313, 9'd293, 9'd273, 9'd254, 9'd234, 9'd215, 9'd195, 9'd176, \
  9'd156, 9'd137, 9'd117, 9'd98, 9'd78, 9'd59, 9'd39, 9'd20}

`endif

/* File: msq_pkg.sv */
package msq_pkg;

  typedef enum logic [4:0] {
    ts_idle   = 5'b00001,
    ts_charge = 5'b00010,
    ts_disch  = 5'b00100,
    ts_next   = 5'b01000,
    ts_done   = 5'b10000
  } msq_tstate_t;

  typedef enum logic [2:0] {
    tk_dummy = 3'b001,
    tk_eval  = 3'b010,
    tk_real  = 3'b100
  } msq_kind_t;

  typedef enum logic [4:0] {
    ss_idle   = 5'b00001,
    ss_wait   = 5'b00010,
    ss_cal    = 5'b00100,
    ss_flight = 5'b01000,
    ss_temp   = 5'b10000
  } msq_sstate_t;

  typedef struct packed {
    logic [15:0] frac;
    logic [15:0] whole;
  } msq_result_t;

  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [31:0]      ctrl;
    logic [4:0]       flags;
    msq_result_t [1:0] res;
    msq_tstate_t      tst;
    msq_kind_t        kind;
    logic             port;
    logic [2:0]       dleft;
    logic [15:0]      ttmr;
    logic             crossed;
    logic [15:0]      ttime;
    logic [15:0]      tfrac;
    logic             topen;
    logic             tfault;
    logic             terr;
    logic             tsingle;
    logic [15:0]      tune;
    logic             charge;
    logic             emul;
    logic             coarse;
    msq_sstate_t      sst;
    logic             run_f;
    logic             run_t;
    logic [17:0]      f_tmr;
    logic [17:0]      t_tmr;
    logic [4:0]       f_left;
    logic [4:0]       t_left;
    logic             f_pend;
    logic             t_pend;
    logic             cal_temp;
    logic [4:0]       f_cnt;
    logic [4:0]       t_cnt;
    logic [15:0]      f_min;
    logic [15:0]      f_max;
    logic [15:0]      span;
    logic [15:0]      t_avg;
    logic             t_avg_vld;
    logic             fstart;
    logic             cstart;
    logic             irq_n;
    logic [31:0]      tick_cnt;
  } msq_state_t;

  typedef struct packed {
    logic [8:0] sr;
  } msq_lfsr_state_t;

endpackage

/* File: msq_lfsr.sv */
`timescale 1ns/1ps
`include "msq_cfg.svh"
module msq_lfsr #(
  parameter logic [8:0] SEED = `MSQ_LFSR_SEED
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  // control
  input  wire logic       step_i,
  // state
  output logic [8:0]      value_o
);
  msq_pkg::msq_lfsr_state_t q;
  msq_pkg::msq_lfsr_state_t d;

  always_comb begin
    d = q;
    if (step_i) begin
      d.sr = {q.sr[7:0], q.sr[8] ^ q.sr[4]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q.sr <= SEED;
    end else begin
      q <= d;
    end
  end

  assign value_o = q.sr;

  // a zero seed would freeze the sequence for good
  a_lfsr_never_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) q.sr != 9'h000)
    else $error("randomizer register reached zero");
endmodule

/* File: msq_top.sv */
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "msq_cfg.svh"
// How it works
// - run 0 to 7 dummy cycles first, count from a 3-bit field
// - dummy cycles go through the internal emulation resistor, not the thermistor
// - a coarse evaluation runs automatically before each real port measurement
// - a 2-bit field picks the start-to-start interval between port measurements
// - on finish store port times; a single command also sets the done flag, interrupt if enabled
// - port time under 8 us stores 0000h, a shorted probe
// - no comparator crossing 2 us past interval: FFFFh, open flag, interrupt
// - a port fault during a real port measurement writes FFFFh to every port result; faults in dummy or evaluation cycles are ignored
// - three schedule commands: flight only, temperature only, both
// - continuous bit set: sequences repeat until a halt command
// - continuous bit clear: stop after one full sequence
// - per-measurement bit: interrupt after each measurement, else at sequence end
// - first random flight sample comes one nominal period after start
// - later samples start the code's minimum plus LFSR value times step weight after the previous start
// - 4-bit rate code, 0.5 Hz steps, own min, max and step weight
// - random intervals come from a 9-bit LFSR, x^9 + x^5 + 1
// - scheduled errors are handled like single ones and never stop the schedule
// - calibration runs in the schedule when its field selects it
// - flight valid count counts only error-free flight measurements
// - report span, maximum minus minimum, of valid flight values per sequence
// - temperature valid count rises after each error-free scheduled measurement
// - erroneous temperature results stay out of the running average
// - flight measurement goes first when both fall due, temperature right after
// - 5-bit field sets flight measurements per sequence, rate from rate field
module msq_top #(
  parameter int unsigned TICK_CYCLES = `MSQ_TICK_NS / `MSQ_CLK_PERIOD_NS,
  parameter logic [63:0] PORT_IV_CYC = {16'(`MSQ_PORT_IV3_NS / `MSQ_CLK_PERIOD_NS),
                                        16'(`MSQ_PORT_IV2_NS / `MSQ_CLK_PERIOD_NS),
                                        16'(`MSQ_PORT_IV1_NS / `MSQ_CLK_PERIOD_NS),
                                        16'(`MSQ_PORT_IV0_NS / `MSQ_CLK_PERIOD_NS)}
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // temperature front end
  input  wire logic        cap_below_i,
  input  wire logic [15:0] tdc_frac_i,
  input  wire logic        port_fault_i,
  output logic             cap_charge_pin_o,
  output logic             emul_sel_o,
  output logic             port_sel_o,
  output logic             coarse_eval_o,
  output logic [15:0]      tune_o,
  // flight and calibration engines
  output logic             flight_start_o,
  input  wire logic        flight_done_i,
  input  wire logic        flight_err_i,
  input  wire logic [15:0] flight_val_i,
  output logic             cal_start_o,
  input  wire logic        cal_done_i,
  // interrupt
  output logic             irq_n_o
);
  localparam logic [15:0]  SHORT_CYC  = 16'(`MSQ_SHORT_NS / `MSQ_CLK_PERIOD_NS);
  localparam logic [15:0]  OPEN_CYC   = 16'(`MSQ_OPEN_NS / `MSQ_CLK_PERIOD_NS);
  localparam logic [15:0]  CHARGE_CYC = 16'((`MSQ_CHARGE_NS + `MSQ_CLK_PERIOD_NS - 1) / `MSQ_CLK_PERIOD_NS);
  localparam logic [239:0] NOM_TBL    = `MSQ_NOM_TBL;
  localparam logic [175:0] MIN_TBL    = `MSQ_MIN_TBL;
  localparam logic [143:0] LSB_TBL    = `MSQ_LSB_TBL;
  localparam logic [31:0]  OPEN_WORD  = {`MSQ_OPEN_VAL, `MSQ_OPEN_VAL};

  msq_pkg::msq_state_t q;
  msq_pkg::msq_state_t d;

  logic [8:0]               lfsr_val;
  logic                     lfsr_step;
  logic                     tick;
  logic                     t_go;
  logic                     seq_load;
  logic                     seq_over;
  logic                     wr_acc;
  logic                     mapped;
  logic [31:0]              rdata;
  logic [4:0]               cmd;
  logic [4:0]               set_f;
  logic [15:0]              iv;
  logic [3:0]               frate;
  logic [3:0]               trate;
  logic [17:0]              next_f;
  logic [17:0]              nom_t;
  msq_pkg::msq_result_t     store;

  msq_lfsr #(
    .SEED (`MSQ_LFSR_SEED)
  ) u_lfsr (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .step_i    (lfsr_step),
    .value_o   (lfsr_val)
  );

  always_comb begin
    d = q;
    set_f = '0;
    t_go = 1'b0;
    seq_load = 1'b0;
    lfsr_step = 1'b0;
    store = q.res[q.port];
    d.fstart = 1'b0;
    d.cstart = 1'b0;
    tick = (q.tick_cnt == 32'(TICK_CYCLES - 1));
    d.tick_cnt = tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;
    iv = PORT_IV_CYC[q.ctrl[`MSQ_F_PORTIV]*16 +: 16];
    frate = q.ctrl[`MSQ_F_FRATE];
    trate = q.ctrl[`MSQ_F_TRATE];
    nom_t = 18'(NOM_TBL[trate*15 +: 15]);
    // random draw from the per-code floor and step weight
    next_f = q.ctrl[`MSQ_F_RAND] ?
             18'(18'(MIN_TBL[frate*11 +: 11]) + 18'(lfsr_val) * 18'(LSB_TBL[frate*9 +: 9])) :
             18'(NOM_TBL[frate*15 +: 15]);
    seq_over = (!q.run_f || q.f_left == 5'h00) && (!q.run_t || q.t_left == 5'h00);

    // register read mux
    mapped = 1'b1;
    if (paddr_i == `MSQ_A_CTRL) begin
      rdata = q.ctrl;
    end else if (paddr_i == `MSQ_A_CMD) begin
      rdata = 32'h0000_0000;
    end else if (paddr_i == `MSQ_A_STAT) begin
      rdata = {26'h0, (q.sst != msq_pkg::ss_idle) || (q.tst != msq_pkg::ts_idle), q.flags};
    end else if (paddr_i == `MSQ_A_RES_REF) begin
      rdata = q.res[0];
    end else if (paddr_i == `MSQ_A_RES_SEN) begin
      rdata = q.res[1];
    end else if (paddr_i == `MSQ_A_FLIGHT) begin
      rdata = {q.span, 11'h000, q.f_cnt};
    end else if (paddr_i == `MSQ_A_TEMP) begin
      rdata = {q.t_avg, 11'h000, q.t_cnt};
    end else begin
      rdata = 32'h0000_0000;
      mapped = 1'b0;
    end

    // one wait-free access phase: ready is raised by the setup cycle
    d.pready = 1'b0;
    if (psel_i && !penable_i) begin
      d.pready = 1'b1;
      d.pslverr = !mapped;
      d.prdata = rdata;
    end
    wr_acc = psel_i && penable_i && pwrite_i && q.pready && !q.pslverr;
    cmd = (wr_acc && paddr_i == `MSQ_A_CMD) ? pwdata_i[4:0] : 5'h00;
    if (wr_acc && paddr_i == `MSQ_A_CTRL) begin
      d.ctrl = pwdata_i & `MSQ_CTRL_MASK;
    end
    if (wr_acc && paddr_i == `MSQ_A_STAT) begin
      d.flags = q.flags & ~pwdata_i[4:0];
    end

    // scheduler timers on the 100 us enable
    if (tick && q.sst != msq_pkg::ss_idle) begin
      if (q.run_f && q.f_left != 5'h00 && !q.f_pend) begin
        if (q.f_tmr <= 18'h00001) d.f_pend = 1'b1;
        else d.f_tmr = q.f_tmr - 18'h00001;
      end
      if (q.run_t && q.t_left != 5'h00 && !q.t_pend) begin
        if (q.t_tmr <= 18'h00001) d.t_pend = 1'b1;
        else d.t_tmr = q.t_tmr - 18'h00001;
      end
    end

    case (q.sst)
      msq_pkg::ss_idle: begin
        if ((cmd[`MSQ_C_FLIGHT] || cmd[`MSQ_C_TEMP] || cmd[`MSQ_C_BOTH]) && q.tst == msq_pkg::ts_idle) begin
          d.run_f = cmd[`MSQ_C_FLIGHT] || cmd[`MSQ_C_BOTH];
          d.run_t = cmd[`MSQ_C_TEMP] || cmd[`MSQ_C_BOTH];
          d.sst = msq_pkg::ss_wait;
          seq_load = 1'b1;
        end else if (cmd[`MSQ_C_SINGLE] && q.tst == msq_pkg::ts_idle) begin
          t_go = 1'b1;
          d.tsingle = 1'b1;
        end
      end
      msq_pkg::ss_wait: begin
        if (seq_over) begin
          if (q.ctrl[`MSQ_F_CONT]) seq_load = 1'b1;
          else d.sst = msq_pkg::ss_idle;
        end else if (q.f_pend) begin
          d.f_pend = 1'b0;
          d.f_tmr = next_f;
          lfsr_step = 1'b1;
          d.cal_temp = 1'b0;
          if (q.ctrl[`MSQ_F_CALB0]) begin
            d.sst = msq_pkg::ss_cal;
            d.cstart = 1'b1;
          end else begin
            d.sst = msq_pkg::ss_flight;
            d.fstart = 1'b1;
          end
        end else if (q.t_pend) begin
          d.t_pend = 1'b0;
          d.t_tmr = nom_t;
          d.cal_temp = 1'b1;
          d.tsingle = 1'b0;
          if (q.ctrl[`MSQ_F_CALB1]) begin
            d.sst = msq_pkg::ss_cal;
            d.cstart = 1'b1;
          end else begin
            d.sst = msq_pkg::ss_temp;
            t_go = 1'b1;
          end
        end
      end
      msq_pkg::ss_cal: begin
        // calibration errors are left to the calibration engine
        if (cal_done_i) begin
          if (q.cal_temp) begin
            d.sst = msq_pkg::ss_temp;
            t_go = 1'b1;
          end else begin
            d.sst = msq_pkg::ss_flight;
            d.fstart = 1'b1;
          end
        end
      end
      msq_pkg::ss_flight: begin
        if (flight_done_i) begin
          d.sst = msq_pkg::ss_wait;
          d.f_left = q.f_left - 5'h01;
          if (!flight_err_i) begin
            d.f_cnt = q.f_cnt + 5'h01;
            if (q.f_cnt == 5'h00 || flight_val_i < q.f_min) d.f_min = flight_val_i;
            if (q.f_cnt == 5'h00 || flight_val_i > q.f_max) d.f_max = flight_val_i;
          end
          set_f[`MSQ_S_MEAS] = q.ctrl[`MSQ_F_IRQPM];
          set_f[`MSQ_S_FSEQ] = (q.f_left == 5'h01);
        end
      end
      msq_pkg::ss_temp: begin
        if (q.tst == msq_pkg::ts_done) begin
          d.sst = msq_pkg::ss_wait;
          d.t_left = q.t_left - 5'h01;
          if (!q.terr) begin
            d.t_cnt = q.t_cnt + 5'h01;
            d.t_avg_vld = 1'b1;
            d.t_avg = q.t_avg_vld ? 16'((17'(q.t_avg) + 17'(q.res[1].whole)) >> 1) : q.res[1].whole;
          end
          set_f[`MSQ_S_MEAS] = q.ctrl[`MSQ_F_IRQPM];
          set_f[`MSQ_S_TSEQ] = (q.t_left == 5'h01);
        end
      end
      default: d.sst = msq_pkg::ss_idle;
    endcase

    if (seq_load) begin
      d.f_left = q.ctrl[`MSQ_F_FCNT];
      d.t_left = q.ctrl[`MSQ_F_TCNT];
      d.f_tmr = 18'(NOM_TBL[frate*15 +: 15]);
      d.t_tmr = nom_t;
      d.f_pend = 1'b0;
      d.t_pend = 1'b0;
      d.f_cnt = 5'h00;
      d.t_cnt = 5'h00;
      d.f_min = 16'h0000;
      d.f_max = 16'h0000;
      d.t_avg_vld = 1'b0;
    end
    d.span = d.f_max - d.f_min;

    // temperature port sequence
    case (q.tst)
      msq_pkg::ts_idle: begin
        if (t_go) begin
          d.tst = msq_pkg::ts_charge;
          d.ttmr = 16'h0000;
          d.port = 1'b0;
          d.tfault = 1'b0;
          d.terr = 1'b0;
          d.dleft = q.ctrl[`MSQ_F_DUMMY];
          d.kind = (q.ctrl[`MSQ_F_DUMMY] != 3'h0) ? msq_pkg::tk_dummy : msq_pkg::tk_eval;
        end
      end
      msq_pkg::ts_charge: begin
        d.ttmr = q.ttmr + 16'h0001;
        if (q.ttmr == CHARGE_CYC - 16'h0001) begin
          d.tst = msq_pkg::ts_disch;
          d.ttmr = 16'h0000;
          d.crossed = 1'b0;
          d.topen = 1'b0;
        end
      end
      msq_pkg::ts_disch: begin
        d.ttmr = q.ttmr + 16'h0001;
        if (cap_below_i && !q.crossed) begin
          d.crossed = 1'b1;
          d.ttime = q.ttmr;
          d.tfrac = tdc_frac_i;
        end
        if (port_fault_i && q.kind == msq_pkg::tk_real) begin
          d.tfault = 1'b1;
          d.terr = 1'b1;
        end
        if (q.crossed && q.ttmr >= iv) begin
          d.tst = msq_pkg::ts_next;
        end else if (!q.crossed && q.ttmr >= 16'(iv + OPEN_CYC)) begin
          d.topen = 1'b1;
          d.tst = msq_pkg::ts_next;
        end
      end
      msq_pkg::ts_next: begin
        d.tst = msq_pkg::ts_charge;
        d.ttmr = 16'h0000;
        case (q.kind)
          msq_pkg::tk_dummy: begin
            d.dleft = q.dleft - 3'h1;
            if (q.dleft == 3'h1) d.kind = msq_pkg::tk_eval;
          end
          msq_pkg::tk_eval: begin
            d.tune = q.topen ? `MSQ_OPEN_VAL : q.ttime;
            d.kind = msq_pkg::tk_real;
          end
          default: begin
            if (q.topen) begin
              store = OPEN_WORD;
              set_f[`MSQ_S_TOPEN] = 1'b1;
              d.terr = 1'b1;
            end else if (q.ttime < SHORT_CYC) begin
              store = {`MSQ_SHORT_VAL, `MSQ_SHORT_VAL};
              d.terr = 1'b1;
            end else begin
              store = {q.tfrac, q.ttime};
            end
            d.res[q.port] = store;
            if (q.port) begin
              d.tst = msq_pkg::ts_done;
            end else begin
              d.port = 1'b1;
              d.kind = msq_pkg::tk_eval;
            end
          end
        endcase
      end
      msq_pkg::ts_done: begin
        d.tst = msq_pkg::ts_idle;
        if (q.tfault) begin
          d.res[0] = OPEN_WORD;
          d.res[1] = OPEN_WORD;
        end
        set_f[`MSQ_S_TDONE] = q.tsingle;
      end
      default: d.tst = msq_pkg::ts_idle;
    endcase

    if (cmd[`MSQ_C_HALT]) begin
      d.sst = msq_pkg::ss_idle;
      d.tst = msq_pkg::ts_idle;
      d.f_pend = 1'b0;
      d.t_pend = 1'b0;
    end

    // hardware set beats a same-cycle software clear
    d.flags = d.flags | set_f;
    d.charge = (d.tst == msq_pkg::ts_charge);
    d.emul = (d.kind == msq_pkg::tk_dummy) && (d.tst != msq_pkg::ts_idle);
    d.coarse = (d.kind == msq_pkg::tk_eval) && (d.tst != msq_pkg::ts_idle);
    d.irq_n = !(d.ctrl[`MSQ_F_INTEN] && (d.flags != 5'h00));
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.ctrl <= `MSQ_CTRL_RST;
      q.tst <= msq_pkg::ts_idle;
      q.sst <= msq_pkg::ss_idle;
      q.kind <= msq_pkg::tk_dummy;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign cap_charge_pin_o = q.charge;
  assign emul_sel_o = q.emul;
  assign port_sel_o = q.port;
  assign coarse_eval_o = q.coarse;
  assign tune_o = q.tune;
  assign flight_start_o = q.fstart;
  assign cal_start_o = q.cstart;
  assign irq_n_o = q.irq_n;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_launch;
    q.tst == msq_pkg::ts_idle ##1 q.tst == msq_pkg::ts_charge;
  endsequence
  sequence s_real_store;
    q.tst == msq_pkg::ts_next && q.kind == msq_pkg::tk_real && !cmd[`MSQ_C_HALT];
  endsequence

  a_dummy_launch: assert property (s_launch |-> emul_sel_o == (q.dleft != 3'h0))
    else $error("dummy routing wrong at launch");
  a_eval_then_real: assert property (q.tst == msq_pkg::ts_next && q.kind == msq_pkg::tk_eval
    && !cmd[`MSQ_C_HALT] |=> q.kind == msq_pkg::tk_real && cap_charge_pin_o && !emul_sel_o)
    else $error("real measurement did not follow evaluation");
  a_short_zero: assert property (s_real_store ##0 (!q.topen && q.ttime < SHORT_CYC)
    |=> q.res[$past(q.port)] == 32'h0000_0000)
    else $error("short probe not stored as zero");
  a_open_store: assert property (s_real_store ##0 q.topen
    |=> q.flags[`MSQ_S_TOPEN] && q.res[$past(q.port)] == OPEN_WORD)
    else $error("open probe not flagged");
  a_fault_all: assert property (q.tst == msq_pkg::ts_done && q.tfault
    |=> q.res[0] == OPEN_WORD && q.res[1] == OPEN_WORD)
    else $error("fault did not invalidate all ports");
  a_halt_idle: assert property (cmd[`MSQ_C_HALT] |=> q.sst == msq_pkg::ss_idle ##1 q.sst == msq_pkg::ss_idle)
    else $error("halt did not stop scheduler");
  a_one_shot_end: assert property (q.sst == msq_pkg::ss_wait && seq_over && !q.ctrl[`MSQ_F_CONT]
    |=> q.sst == msq_pkg::ss_idle)
    else $error("single sequence did not stop");
  a_flight_first: assert property (q.sst == msq_pkg::ss_wait && !seq_over && q.f_pend && q.t_pend
    && !cmd[`MSQ_C_HALT] |=> q.t_pend && !q.f_pend && q.sst != msq_pkg::ss_temp)
    else $error("temperature overtook flight");
  a_err_no_count: assert property (q.sst == msq_pkg::ss_flight && flight_done_i && flight_err_i
    |=> $stable(q.f_cnt))
    else $error("flight count moved on error");
  a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("apb access not answered");
endmodule

/* File: msq_front_model.sv */
`timescale 1ns/1ps
module msq_front_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // temperature side
  input  wire logic        charge_i,
  input  wire logic        emul_i,
  input  wire logic        coarse_i,
  input  wire logic [15:0] dly_i,
  output logic             cap_below_o,
  output logic [7:0]       dummies_o,
  output logic [7:0]       evals_o,
  // flight and calibration side
  input  wire logic        flight_start_i,
  input  wire logic [4:0]  err_mask_i,
  output logic             flight_done_o,
  output logic             flight_err_o,
  output logic [15:0]      flight_val_o,
  output logic [7:0]       starts_o,
  input  wire logic        cal_start_i,
  output logic             cal_done_o
);
  logic [15:0] t_q;
  logic [15:0] val_q;
  logic        err_q;
  logic        chg_q;
  logic [2:0]  fc_q;
  logic [1:0]  cc_q;
  // stale data lines flip outside the done cycle
  assign flight_val_o = flight_done_o ? val_q : ~val_q;
  assign flight_err_o = flight_done_o ? err_q : ~err_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {t_q, val_q, err_q, chg_q, fc_q, cc_q} <= '0;
      {cap_below_o, dummies_o, evals_o, flight_done_o, starts_o, cal_done_o} <= '0;
    end else begin
      chg_q <= charge_i;
      if (charge_i) begin
        t_q <= '0;
        cap_below_o <= 1'b0;
      end else begin
        t_q <= t_q + 16'h1;
        if (t_q >= dly_i) cap_below_o <= 1'b1;
      end
      if (charge_i && !chg_q && emul_i) dummies_o <= dummies_o + 8'h1;
      if (charge_i && !chg_q && coarse_i) evals_o <= evals_o + 8'h1;
      if (flight_start_i) begin
        fc_q <= 3'h5;
        starts_o <= starts_o + 8'h1;
        val_q <= 16'h64 + 16'h32 * 16'(starts_o);
        err_q <= err_mask_i[starts_o[2:0]];
      end else if (fc_q != 3'h0) fc_q <= fc_q - 3'h1;
      flight_done_o <= (fc_q == 3'h1);
      if (cal_start_i) cc_q <= 2'h3;
      else if (cc_q != 2'h0) cc_q <= cc_q - 2'h1;
      cal_done_o <= (cc_q == 2'h1);
    end
  end
endmodule

/* File: msq_top_tb.sv */
`timescale 1ns/1ps
module msq_top_tb;
  logic ref_clk_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, pfault = 0, err;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, rd, prdata;
  logic [15:0] dly = 16'd1000, fval, tune;
  logic pready, pslverr, below, chg, emul, psel_o, coarse, fst, fdone, ferr, cst, cdone, irq;
  logic [7:0] dums, evs, starts;
  int n_errors = 0, compares = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  msq_top #(.TICK_CYCLES(5), .PORT_IV_CYC({16'd1200, 16'd1100, 16'd1000, 16'd900})) dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cap_below_i(below), .tdc_frac_i(16'hA5C3), .port_fault_i(pfault), .cap_charge_pin_o(chg),
    .emul_sel_o(emul), .port_sel_o(psel_o), .coarse_eval_o(coarse), .tune_o(tune),
    .flight_start_o(fst), .flight_done_i(fdone), .flight_err_i(ferr), .flight_val_i(fval),
    .cal_start_o(cst), .cal_done_i(cdone), .irq_n_o(irq));
  msq_front_model fm (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .charge_i(chg), .emul_i(emul), .coarse_i(coarse),
    .dly_i(dly), .cap_below_o(below), .dummies_o(dums), .evals_o(evs), .flight_start_i(fst),
    .err_mask_i(5'h02), .flight_done_o(fdone), .flight_err_o(ferr), .flight_val_o(fval),
    .starts_o(starts), .cal_start_i(cst), .cal_done_o(cdone));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  // polls status, bounded; the watchdog covers a hang
  task automatic waitb(input int b, input logic v);
    for (int i = 0; i < 40000 && rd[b] !== v; i++) apb(1'b0, 12'h008, '0);
  endtask
  task automatic temp(input logic [15:0] d, input logic f);
    dly <= d;
    pfault <= f;
    apb(1'b1, 12'h008, 32'h1F);
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b0, 12'h008, '0);
    waitb(5, 1'b0);
  endtask
  task automatic final_report;
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, 12'h000, '0); chk("ctrl_rst", rd, 32'h0);
    apb(1'b0, 12'h020, '0); chk("unmapped", {rd[31:1], err}, 32'h1);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF); apb(1'b0, 12'h000, '0); chk("ctrl_mask", rd, 32'h3FFF_FFFF);
    apb(1'b1, 12'h000, 32'h0100_0002);
    temp(16'd1000, 1'b0);
    chk("tdone", rd[0], 1'b1);
    chk("irq_done", irq, 1'b0);
    chk("dummies", dums, 8'h2);
    chk("evals", evs, 8'h2);
    apb(1'b0, 12'h00C, '0); chk("ref_frac", rd[31:16], 16'hA5C3);
    chk("ref_int", rd[15:0] > 16'd995 && rd[15:0] < 16'd1005, 1'b1);
    apb(1'b0, 12'h010, '0); chk("sen_frac", rd[31:16], 16'hA5C3);
    temp(16'd500, 1'b0);
    apb(1'b0, 12'h00C, '0); chk("short", rd, 32'h0);
    temp(16'd5000, 1'b0);
    chk("open_flag", rd[1], 1'b1);
    apb(1'b0, 12'h00C, '0); chk("open_res", rd, 32'hFFFF_FFFF);
    temp(16'd1000, 1'b1);
    apb(1'b0, 12'h00C, '0); chk("fault_ref", rd, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, '0); chk("fault_sen", rd, 32'hFFFF_FFFF);
    pfault <= 1'b0;
    apb(1'b1, 12'h008, 32'h1F);
    apb(1'b1, 12'h000, 32'h0100_1F80);
    apb(1'b1, 12'h004, 32'h1);
    waitb(2, 1'b1);
    chk("fseq", rd[2], 1'b1);
    chk("irq_seq", irq, 1'b0);
    apb(1'b0, 12'h008, '0); chk("idle", rd[5], 1'b0);
    chk("starts", starts, 8'h3);
    apb(1'b0, 12'h014, '0); chk("fstats", rd, 32'h0064_0002);
    apb(1'b1, 12'h008, 32'h1F);
    apb(1'b1, 12'h000, 32'h3F21_0FA8);
    apb(1'b1, 12'h004, 32'h4);
    waitb(3, 1'b1);
    apb(1'b0, 12'h008, '0); chk("both_cont", rd[5:2], 4'hB);
    chk("cal_flight", starts, 8'h4);
    apb(1'b1, 12'h004, 32'h8);
    apb(1'b0, 12'h008, '0); chk("halted", rd[5], 1'b0);
    apb(1'b0, 12'h018, '0); chk("t_avg", rd[31:16] > 16'd995 && rd[31:16] < 16'd1005, 1'b1);
    final_report;
  end
endmodule
